// ==== icf_defines.svh ====
// Purpose: Offsets, field positions, reset values and vectors of the interrupt flag block
// Assumes: APB byte addresses, one 32-bit word per 8-bit register
// Notes: Included by icf_pkg, icf_top and icf_properties
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

`define ICF_ADDR_W 8
`define ICF_OFF_MAIN 8'h00
`define ICF_OFF_EDGE 8'h04
`define ICF_OFF_EXT 8'h08
`define ICF_OFF_PFLAG 8'h0C
`define ICF_OFF_RCTL 8'h10
`define ICF_OFF_PEN 8'h14
`define ICF_OFF_PPRIO 8'h18

`define ICF_RST_MAIN 8'h00
`define ICF_RST_EDGE 8'hFF
`define ICF_RST_EXT 8'hC0
`define ICF_RST_PFLAG 8'h00
`define ICF_RST_PEN 8'h00
`define ICF_RST_PPRIO 8'hFF

// Main register fields
`define ICF_M_GIE 7
`define ICF_M_PEIE 6
`define ICF_M_TAE 5
`define ICF_M_E0E 4
`define ICF_M_PCE 3
`define ICF_M_TAF 2
`define ICF_M_E0F 1
`define ICF_M_PCF 0
// Edge/priority register fields
`define ICF_E_PUD 7
`define ICF_E_EDG0 6
`define ICF_E_TAP 2
`define ICF_E_E3P 1
`define ICF_E_PCP 0
// External-line register fields
`define ICF_X_E2P 7
`define ICF_X_E1P 6
`define ICF_X_E3E 5
`define ICF_X_E2E 4
`define ICF_X_E1E 3
`define ICF_X_E3F 2
`define ICF_X_E2F 1
`define ICF_X_E1F 0
// Peripheral flag fields
`define ICF_P_CONV 6
`define ICF_P_RXF 5
`define ICF_P_TXE 4
`define ICF_P_SSD 3
`define ICF_P_TBM 1
`define ICF_P_TCO 0
`define ICF_P_MASK 8'h7B
`define ICF_P_SWMASK 8'h4B
// Reset control register field
`define ICF_R_PRIORITY_MODE_ENABLE 7

`define ICF_VEC_HIGH 16'h0008
`define ICF_VEC_LOW 16'h0018

`endif

// ==== icf_pkg.sv ====
// Purpose: Types of the interrupt flag block
// Assumes: Constants come from icf_defines.svh
// Notes: State of the top module is one packed struct
`include "icf_defines.svh"

package icf_pkg;

  typedef struct packed {
    logic [7:0] main;
    logic [7:0] edge_cfg;
    logic [7:0] ext;
    logic [7:0] pflag;
    logic [7:0] pen;
    logic [7:0] pprio;
    logic priority_mode_enable;
    logic [3:0] ext_prev;
    logic [3:0] port_snap;
    logic in_high;
    logic in_low;
    logic [31:0] prdata;
    logic [15:0] vector;
  } icf_state_type;

endpackage : icf_pkg

// ==== icf_top.sv ====
// Purpose: Interrupt enable, priority and flag logic with APB register access
// Assumes: All event inputs are synchronous to pclk; pulses last one cycle
// Notes: Zero-wait-state APB slave; read data captured in the setup cycle
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "icf_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Event flags set on their condition regardless of any enable bit.
// - Compatibility mode: main bit 7 enables all unmasked, 0 blocks all.
// - Priority mode: main bit 7 enables high priority, 0 blocks all.
// - Compatibility mode: main bit 6 gates all peripheral sources.
// - Priority mode: main bit 6 enables low-priority sources.
// - Main bits 5,4,3 enable timer A, line 0, port change.
// - Main bit 2 sets on timer A overflow, sticky until cleared.
// - Main bit 1 sets on line 0 active edge, sticky until cleared.
// - Main bit 0 sets on any upper change-port pin change, sticky.
// - Mismatch keeps setting port flag; a port read ends mismatch.
// - Edge register bit 7 disables all pull-ups, else latch values rule.
// - Edge register bits 6..3 pick rising or falling edge, lines 0..3.
// - Edge register bits 2,1,0 set priority of timer A, line 3, port.
// - Line register bits 7,6 set priority of lines 2 and 1.
// - Line register bits 5,4,3 enable lines 3,2,1.
// - Line register bits 2,1,0 flag edges on lines 3,2,1, sticky.
// - Peripheral bit 6 sets on conversion done, sticky.
// - Peripheral bit 5 reads serial receive buffer full, read-only.
// - Peripheral bit 4 reads serial transmit buffer empty, read-only.
// - Peripheral bit 3 sets on synchronous serial transfer done, sticky.
// - Peripheral bits 1,0 set on timer B match, timer C overflow.
// - Reset control bit 7 enables priority mode; cleared by default.
// - Request vectors 0008h high, 0018h low; compatibility uses 0008h.
// - Response clears the global enable (main bit 6 for a low-priority one); return sets it; high preempts.
module icf_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ICF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire logic timer_a_overflow,
  input wire logic [3:0] ext_line,
  input wire logic [7:4] change_port,
  input wire logic change_port_read,
  input wire logic [7:0] change_port_latch,
  input wire logic conversion_done,
  input wire logic serial1_rx_full,
  input wire logic serial1_tx_empty,
  input wire logic sync_serial_done,
  input wire logic timer_b_period_match,
  input wire logic timer_c_overflow,
  // Pull-up control
  output logic change_port_pullup_disable,
  output logic [7:0] change_port_pullup_en,
  // Processor core
  input wire logic core_int_ack,
  input wire logic core_int_return,
  output logic irq_high,
  output logic irq_low,
  output logic [15:0] irq_vector
);

  icf_pkg::icf_state_type s_q;
  icf_pkg::icf_state_type s_d;

  logic setup;
  logic access;
  logic mapped;
  logic do_wr;
  logic [3:0] ext_rise;
  logic [3:0] ext_act;
  logic [3:0] ext_hit;
  logic port_mismatch;
  logic [7:0] pflag_view;
  logic [6:0] src_req;
  logic [6:0] src_high;
  logic [7:0] p_req;
  logic core_any;
  logic core_hi;
  logic core_lo;
  logic per_any;
  logic per_hi;
  logic per_lo;
  logic req_h;
  logic req_l;

  function automatic logic hit(input logic [`ICF_ADDR_W-1:0] a, input logic [`ICF_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = hit(paddr, `ICF_OFF_MAIN) | hit(paddr, `ICF_OFF_EDGE) | hit(paddr, `ICF_OFF_EXT) |
                  hit(paddr, `ICF_OFF_PFLAG) | hit(paddr, `ICF_OFF_RCTL) | hit(paddr, `ICF_OFF_PEN) |
                  hit(paddr, `ICF_OFF_PPRIO);
  // Only the low byte lane holds register bits
  assign do_wr = access & pwrite & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = s_q.prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  // Edge select per line: 1 rising, 0 falling
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      assign ext_rise[gi] = ext_line[gi] & ~s_q.ext_prev[gi];
      assign ext_act[gi] = ~ext_line[gi] & s_q.ext_prev[gi];
      assign ext_hit[gi] = s_q.edge_cfg[`ICF_E_EDG0 - gi] ? ext_rise[gi] : ext_act[gi];
    end
  endgenerate

  // Compared with the value captured at the last port read, so the flag keeps re-arming
  // until software reads the port
  assign port_mismatch = (change_port != s_q.port_snap);

  // Buffer-state bits are live copies of the serial port levels
  always_comb begin
    pflag_view = s_q.pflag & `ICF_P_SWMASK;
    pflag_view[`ICF_P_RXF] = serial1_rx_full;
    pflag_view[`ICF_P_TXE] = serial1_tx_empty;
  end

  assign change_port_pullup_disable = s_q.edge_cfg[`ICF_E_PUD];
  assign change_port_pullup_en = s_q.edge_cfg[`ICF_E_PUD] ? 8'h00 : change_port_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Request gating

  // Core sources: timer A, line 0, port change, lines 1..3
  assign src_req = {s_q.main[`ICF_M_TAF] & s_q.main[`ICF_M_TAE],
                    s_q.main[`ICF_M_E0F] & s_q.main[`ICF_M_E0E],
                    s_q.main[`ICF_M_PCF] & s_q.main[`ICF_M_PCE],
                    s_q.ext[`ICF_X_E3F] & s_q.ext[`ICF_X_E3E],
                    s_q.ext[`ICF_X_E2F] & s_q.ext[`ICF_X_E2E],
                    s_q.ext[`ICF_X_E1F] & s_q.ext[`ICF_X_E1E],
                    1'b0};
  // Line 0 has no priority bit and is always high priority
  assign src_high = {s_q.edge_cfg[`ICF_E_TAP], 1'b1, s_q.edge_cfg[`ICF_E_PCP],
                     s_q.edge_cfg[`ICF_E_E3P], s_q.ext[`ICF_X_E2P], s_q.ext[`ICF_X_E1P], 1'b0};
  assign p_req = pflag_view & s_q.pen & `ICF_P_MASK;

  assign core_any = |src_req;
  assign core_hi = |(src_req & src_high);
  assign core_lo = |(src_req & ~src_high);
  assign per_any = |p_req;
  assign per_hi = |(p_req & s_q.pprio);
  assign per_lo = |(p_req & ~s_q.pprio);

  always_comb begin
    if (s_q.priority_mode_enable) begin
      req_h = s_q.main[`ICF_M_GIE] & (core_hi | per_hi);
      // Low level also needs the high enable, which is what holds it off during high service
      req_l = s_q.main[`ICF_M_GIE] & s_q.main[`ICF_M_PEIE] & (core_lo | per_lo);
    end else begin
      req_h = s_q.main[`ICF_M_GIE] & (core_any | (s_q.main[`ICF_M_PEIE] & per_any));
      req_l = 1'b0;
    end
  end

  assign irq_high = req_h;
  assign irq_low = req_l;
  assign irq_vector = s_q.vector;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.ext_prev = ext_line;
    if (change_port_read) begin
      s_d.port_snap = change_port;
    end
    s_d.vector = (req_h | ~req_l) ? `ICF_VEC_HIGH : `ICF_VEC_LOW;

    // Register writes land at the access edge
    if (do_wr) begin
      if (hit(paddr, `ICF_OFF_MAIN)) s_d.main = pwdata[7:0];
      if (hit(paddr, `ICF_OFF_EDGE)) s_d.edge_cfg = pwdata[7:0];
      if (hit(paddr, `ICF_OFF_EXT)) s_d.ext = pwdata[7:0];
      if (hit(paddr, `ICF_OFF_PFLAG)) s_d.pflag = pwdata[7:0] & `ICF_P_SWMASK;
      if (hit(paddr, `ICF_OFF_RCTL)) s_d.priority_mode_enable = pwdata[`ICF_R_PRIORITY_MODE_ENABLE];
      if (hit(paddr, `ICF_OFF_PEN)) s_d.pen = pwdata[7:0] & `ICF_P_MASK;
      if (hit(paddr, `ICF_OFF_PPRIO)) s_d.pprio = pwdata[7:0] & `ICF_P_MASK;
    end

    // Core response and return; applied after writes so hardware wins
    if (core_int_ack) begin
      if (s_q.priority_mode_enable & ~req_h & req_l) begin
        s_d.main[`ICF_M_PEIE] = 1'b0;
        s_d.in_low = 1'b1;
      end else if (req_h) begin
        s_d.main[`ICF_M_GIE] = 1'b0;
        s_d.in_high = s_q.priority_mode_enable;
      end
    end else if (core_int_return) begin
      if (s_q.priority_mode_enable & ~s_q.in_high & s_q.in_low) begin
        s_d.main[`ICF_M_PEIE] = 1'b1;
        s_d.in_low = 1'b0;
      end else begin
        s_d.main[`ICF_M_GIE] = 1'b1;
        s_d.in_high = 1'b0;
      end
    end

    // Sticky flags: an event in the clearing cycle is kept
    if (timer_a_overflow) s_d.main[`ICF_M_TAF] = 1'b1;
    if (ext_hit[0]) s_d.main[`ICF_M_E0F] = 1'b1;
    if (port_mismatch) s_d.main[`ICF_M_PCF] = 1'b1;
    if (ext_hit[3]) s_d.ext[`ICF_X_E3F] = 1'b1;
    if (ext_hit[2]) s_d.ext[`ICF_X_E2F] = 1'b1;
    if (ext_hit[1]) s_d.ext[`ICF_X_E1F] = 1'b1;
    if (conversion_done) s_d.pflag[`ICF_P_CONV] = 1'b1;
    if (sync_serial_done) s_d.pflag[`ICF_P_SSD] = 1'b1;
    if (timer_b_period_match) s_d.pflag[`ICF_P_TBM] = 1'b1;
    if (timer_c_overflow) s_d.pflag[`ICF_P_TCO] = 1'b1;

    // Read data is captured in the setup cycle so the access phase needs no wait state
    if (setup & ~pwrite) begin
      s_d.prdata = 32'h0000_0000;
      if (hit(paddr, `ICF_OFF_MAIN)) s_d.prdata[7:0] = s_q.main;
      if (hit(paddr, `ICF_OFF_EDGE)) s_d.prdata[7:0] = s_q.edge_cfg;
      if (hit(paddr, `ICF_OFF_EXT)) s_d.prdata[7:0] = s_q.ext;
      if (hit(paddr, `ICF_OFF_PFLAG)) s_d.prdata[7:0] = pflag_view;
      if (hit(paddr, `ICF_OFF_RCTL)) s_d.prdata[`ICF_R_PRIORITY_MODE_ENABLE] = s_q.priority_mode_enable;
      if (hit(paddr, `ICF_OFF_PEN)) s_d.prdata[7:0] = s_q.pen;
      if (hit(paddr, `ICF_OFF_PPRIO)) s_d.prdata[7:0] = s_q.pprio;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.main <= `ICF_RST_MAIN;
      s_q.edge_cfg <= `ICF_RST_EDGE;
      s_q.ext <= `ICF_RST_EXT;
      s_q.pflag <= `ICF_RST_PFLAG;
      s_q.pen <= `ICF_RST_PEN;
      s_q.pprio <= `ICF_RST_PPRIO;
      s_q.priority_mode_enable <= 1'b0;
      s_q.ext_prev <= 4'h0;
      s_q.port_snap <= 4'h0;
      s_q.in_high <= 1'b0;
      s_q.in_low <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
      s_q.vector <= `ICF_VEC_HIGH;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : icf_top

// ==== icf_properties.sv ====
// Purpose: Port-level assertions for the interrupt flag block
// Assumes: One clock domain, async active-low reset
// Notes: Bound into icf_top, sees ports only
`timescale 1ns/1ps
`include "icf_defines.svh"
module icf_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [`ICF_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pull-ups
  input wire logic [7:0] change_port_latch,
  input wire logic change_port_pullup_disable,
  input wire logic [7:0] change_port_pullup_en,
  // Core
  input wire logic core_int_ack,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic [15:0] irq_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  unmapped_err_a: assert property (psel && penable && paddr > `ICF_OFF_PPRIO |-> pslverr)
    else $error("no slave error on unmapped address");
  upper_zero_a: assert property (psel && !penable |=> prdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  pullup_off_a: assert property (change_port_pullup_disable |-> change_port_pullup_en == 8'h00)
    else $error("pull-ups on while disabled");
  pullup_follow_a: assert property (!change_port_pullup_disable |-> change_port_pullup_en == change_port_latch)
    else $error("pull-ups do not follow latch");
  vec_high_a: assert property (irq_high |=> irq_vector == `ICF_VEC_HIGH)
    else $error("high request without high vector");
  vec_low_a: assert property (irq_low && !irq_high |=> irq_vector == `ICF_VEC_LOW)
    else $error("low request without low vector");
  ack_drop_a: assert property (core_int_ack && irq_high |=> !irq_high)
    else $error("request stays after response");
  low_drop_a: assert property (core_int_ack && irq_low && !irq_high |=> !irq_low)
    else $error("low request stays after response");
  rst_quiet_a: assert property ($rose(presetn) |-> !irq_high && !irq_low && irq_vector == `ICF_VEC_HIGH)
    else $error("requests active out of reset");
endmodule : icf_properties
////////////////////////////////////////////////////////////////////////////////
bind icf_top icf_properties chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
  .change_port_latch, .change_port_pullup_disable, .change_port_pullup_en, .core_int_ack,
  .irq_high, .irq_low, .irq_vector);

// ==== icf_core_model.sv ====
// Purpose: Processor core stand-in that responds to requests and returns
// Assumes: Responds only while serve_en is high; returns regardless of serve_en
// Notes: delay sets both response and return latency
`timescale 1ns/1ps
module icf_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests and control
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic serve_en,
  input wire logic [3:0] delay,
  // Core pulses
  output logic ack,
  output logic ret
);
  logic busy;
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
      ret <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
    end else begin
      ack <= 1'b0;
      ret <= 1'b0;
      cnt <= cnt + 4'h1;
      if (!busy && serve_en && (irq_high || irq_low) && cnt >= delay) begin
        ack <= 1'b1;
        busy <= 1'b1;
        cnt <= 4'h0;
      end else if (busy && cnt >= delay) begin
        ret <= 1'b1;
        busy <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule : icf_core_model

// ==== interrupt_control_flags_test.sv ====
// Purpose: Self-checking bench for the interrupt flag block
// Assumes: Register model mdl tracks writes and events
// Notes: Idle cycle after each APB transfer keeps drivers single per step
`timescale 1ns/1ps
module interrupt_control_flags_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cp_rd, rx, tx, ack, ret, srv, e, hi, lo, pu_dis;
  logic [7:0] paddr, lat, pu_en;
  logic [31:0] pwdata, prdata, r;
  logic [4:0] ev;
  logic [3:0] ext, cp, dly;
  logic [15:0] vec;
  logic [7:0] mdl [7];
  int ev_reg [5] = '{0, 3, 3, 3, 3};
  int ev_bit [5] = '{2, 6, 3, 1, 0};
  logic [7:0] mv [5] = '{8'h24, 8'hA4, 8'h84, 8'hC4, 8'h44};
  logic [7:0] pp [4] = '{8'h00, 8'h00, 8'h40, 8'h00};
  logic [7:0] pm [4] = '{8'hC0, 8'h40, 8'h80, 8'h80};
  logic [1:0] pq [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
  int err_count, n_tests;
  icf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_a_overflow(ev[0]), .ext_line(ext), .change_port(cp), .change_port_read(cp_rd),
    .change_port_latch(lat), .conversion_done(ev[1]), .serial1_rx_full(rx), .serial1_tx_empty(tx),
    .sync_serial_done(ev[2]), .timer_b_period_match(ev[3]), .timer_c_overflow(ev[4]),
    .change_port_pullup_disable(pu_dis), .change_port_pullup_en(pu_en), .core_int_ack(ack),
    .core_int_return(ret), .irq_high(hi), .irq_low(lo), .irq_vector(vec));
  icf_core_model core (.pclk(pclk), .presetn(presetn), .irq_high(hi), .irq_low(lo), .serve_en(srv),
    .delay(dly), .ack(ack), .ret(ret));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a transfer that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    chk(r, {24'h0, (i == 3) ? (mdl[3] & 8'h4B | {2'b0, rx, tx, 4'h0}) : mdl[i]});
  endtask : rd
  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), {24'h0, d});
    mdl[i] = d;
  endtask : wr
  task automatic pulse(input int j);
    ev[j] <= 1'b1;
    @(posedge pclk);
    ev[j] <= 1'b0;
    @(posedge pclk);
    mdl[ev_reg[j]][ev_bit[j]] = 1'b1;
  endtask : pulse
  task automatic wait_hi(input bit want_ret);
    int n;
    n = 0;
    while (((want_ret ? ret : ack) !== 1'b1) && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) err_count++;
  endtask : wait_hi
  task test_done;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #(3000 * 100);
    err_count++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, cp_rd, rx, tx, srv, ev, ext, cp, lat, paddr, pwdata} = '0;
    dly = 4'hA;
    mdl = '{8'h00, 8'hFF, 8'hC0, 8'h00, 8'h00, 8'h00, 8'hFF};
    void'($urandom(50386));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pu_dis, pu_en}, {1'b1, 8'h00});
    for (int i = 0; i < 7; i++) rd(i);
    apb(1'b1, 8'h1C, 32'hFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    for (int j = 0; j < 5; j++) pulse(j);
    ext <= 4'hF;
    rx <= 1'b1;
    tx <= 1'b1;
    @(posedge pclk);
    ext <= 4'h0;
    @(posedge pclk);
    mdl[0][1] = 1'b1;
    mdl[2][2:0] = 3'h7;
    for (int i = 0; i < 4; i++) rd(i);
    wr(3, 8'h00);
    rd(3);
    cp <= 4'($urandom_range(15, 1));
    repeat (2) @(posedge pclk);
    mdl[0][0] = 1'b1;
    rd(0);
    wr(0, 8'h00);
    mdl[0][0] = 1'b1;
    rd(0);
    cp_rd <= 1'b1;
    @(posedge pclk);
    cp_rd <= 1'b0;
    repeat (2) @(posedge pclk);
    wr(0, 8'h00);
    rd(0);
    {rx, tx} <= 2'b00;
    wr(2, 8'hC0);
    wr(5, 8'h40);
    pulse(0);
    pulse(1);
    for (int k = 0; k < 5; k++) begin
      wr(0, mv[k]);
      chk({hi, lo}, {mv[k][7] & (mv[k][5] | mv[k][6]), 1'b0});
      @(posedge pclk);
      chk(vec, 16'h0008);
    end
    wr(0, 8'hA4);
    srv <= 1'b1;
    wait_hi(1'b0);
    srv <= 1'b0;
    @(posedge pclk);
    chk({hi, lo}, 2'b00);
    mdl[0] = 8'h24;
    rd(0);
    wait_hi(1'b1);
    @(posedge pclk);
    mdl[0] = 8'hA4;
    rd(0);
    chk({hi, lo}, 2'b10);
    wr(4, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(6, pp[k]);
      wr(0, pm[k]);
      chk({hi, lo}, pq[k]);
      @(posedge pclk);
      chk(vec, (pq[k] == 2'b01) ? 16'h0018 : 16'h0008);
    end
    // Low-level service: only the low enable drops, and return restores it
    wr(0, 8'hC0);
    srv <= 1'b1;
    wait_hi(1'b0);
    srv <= 1'b0;
    @(posedge pclk);
    chk({hi, lo}, 2'b00);
    mdl[0] = 8'h80;
    rd(0);
    wait_hi(1'b1);
    @(posedge pclk);
    mdl[0] = 8'hC0;
    rd(0);
    chk({hi, lo}, 2'b01);
    wr(1, 8'h00);
    lat <= 8'($urandom);
    @(posedge pclk);
    chk({pu_dis, pu_en}, {1'b0, lat});
    ext <= 4'hF;
    repeat (2) @(posedge pclk);
    rd(2);
    ext <= 4'h0;
    repeat (2) @(posedge pclk);
    mdl[0][1] = 1'b1;
    mdl[2][2:0] = 3'h7;
    rd(0);
    rd(2);
    wr(3, 8'h00);
    wr(2, 8'h4F);
    chk({hi, lo}, 2'b10);
    wr(2, 8'h17);
    chk({hi, lo}, 2'b01);
    wr(2, 8'h27);
    chk({hi, lo}, 2'b01);
    wr(1, 8'h02);
    chk({hi, lo}, 2'b10);
    wr(1, 8'h80);
    chk({pu_dis, pu_en}, {1'b1, 8'h00});
    test_done();
  end
endmodule : interrupt_control_flags_test
